// File: logic/dors_pkg.sv
// constants for the dual output route select block
// assumes a byte-wide register port driven by the serial management logic
package dors_pkg;
  localparam logic [7:0] ADDR_FIRST_ROUTE = 8'h1c;
  localparam logic [7:0] ADDR_RSVD_1D = 8'h1d;
  localparam logic [7:0] ADDR_SECOND_ROUTE = 8'h1e;
  localparam logic [7:0] ADDR_SECOND_POL = 8'h1f;
  localparam logic [7:0] ADDR_RSVD_20 = 8'h20;
  localparam logic [7:0] ADDR_RSVD_21 = 8'h21;
  localparam logic [7:0] ADDR_RSVD_22 = 8'h22;

  localparam logic [7:0] RST_FIRST_ROUTE = 8'h58;
  localparam logic [7:0] RST_SECOND_ROUTE = 8'h09;
  localparam logic [7:0] RST_SECOND_POL = 8'h10;

  localparam int ROUTE_MSB = 7;
  localparam int ROUTE_LSB = 5;
  localparam int DIV_CHOICE_BIT = 4;
  localparam int CTRL_MSB = 3;
  localparam int CTRL_LSB = 2;
  localparam int INVERT_BIT = 7;

  // first output route codes
  localparam logic [2:0] R0_MUTE = 3'h0;
  localparam logic [2:0] R0_CLK10M = 3'h1;
  localparam logic [2:0] R0_RAW = 3'h2;
  localparam logic [2:0] R0_RETIMED = 3'h4;
  // second output route codes
  localparam logic [2:0] R1_RAW = 3'h0;
  localparam logic [2:0] R1_RETIMED = 3'h1;
  localparam logic [2:0] R1_VCO = 3'h2;
  localparam logic [2:0] R1_DIVIDED = 3'h5;
  localparam logic [2:0] R1_MUTE = 3'h7;

  typedef enum logic [1:0] {
    DORS_CTRL_MUTE = 2'h0,
    DORS_CTRL_CLOCK = 2'h1,
    DORS_CTRL_RETIME = 2'h2,
    DORS_CTRL_RAW = 2'h3
  } dors_ctrl_t;
endpackage

// File: logic/dors_route_select.sv
// route selection for the two serial outputs, polarity control for the second output only
// assumes override enables come from other registers on clk_i; the
// output-control pin, lock and rate flags arrive asynchronously
`timescale 1ns/1ps

module dors_route_select (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic route_override_i,
  input wire logic ctrl_pin_override_i,
  input wire logic [1:0] out_ctrl_pin_i,
  input wire logic cdr_locked_i,
  input wire logic rate_above_3g_i,
  output logic [2:0] first_output_route_code_o,
  output logic [2:0] second_output_route_code_o,
  output logic divided_clock_choice_o,
  output logic second_output_invert_o
);
  logic [7:0] first_route_reg;
  logic [7:0] second_route_reg;
  logic [7:0] second_pol_reg;
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] stat_meta;
  logic [1:0] stat_sync;
  logic locked;
  logic above_3g;
  logic [1:0] ctrl_code;
  logic [2:0] next_first;
  logic [2:0] next_second;
  logic next_div;

  // route field of a stored byte
  function automatic logic [2:0] route_field(input logic [7:0] stored);
    return stored[dors_pkg::ROUTE_MSB:dors_pkg::ROUTE_LSB];
  endfunction

  // readback byte: applied code on top, stored low bits below it
  function automatic logic [7:0] readback(input logic [2:0] applied, input logic [7:0] stored);
    return {applied, stored[dors_pkg::ROUTE_LSB-1:0]};
  endfunction

  // one address decode shared by the three write blocks
  function automatic logic write_hit(input logic wr, input logic [7:0] addr, input logic [7:0] want);
    return wr && (addr == want);
  endfunction

  assign locked = stat_sync[0];
  assign above_3g = stat_sync[1];

  // pin comes from outside this clock
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end
    else
    begin
      pin_meta <= out_ctrl_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // lock and rate are unrelated to clk_i; each bit may land a cycle apart
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stat_meta <= 2'h0;
      stat_sync <= 2'h0;
    end
    else
    begin
      stat_meta <= {rate_above_3g_i, cdr_locked_i};
      stat_sync <= stat_meta;
    end
  end

  // writes to reserved bytes miss every decode and are dropped
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      first_route_reg <= dors_pkg::RST_FIRST_ROUTE;
    else if (write_hit(reg_wr_i, reg_addr_i, dors_pkg::ADDR_FIRST_ROUTE))
      first_route_reg <= reg_wdata_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      second_route_reg <= dors_pkg::RST_SECOND_ROUTE;
    else if (write_hit(reg_wr_i, reg_addr_i, dors_pkg::ADDR_SECOND_ROUTE))
      second_route_reg <= reg_wdata_i;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      second_pol_reg <= dors_pkg::RST_SECOND_POL;
    else if (write_hit(reg_wr_i, reg_addr_i, dors_pkg::ADDR_SECOND_POL))
      second_pol_reg <= reg_wdata_i;
  end

  // field replaces the pin only when enabled
  assign ctrl_code = ctrl_pin_override_i ? first_route_reg[dors_pkg::CTRL_MSB:dors_pkg::CTRL_LSB]
                                         : pin_sync;

  always_comb
  begin
    next_first = dors_pkg::R0_MUTE;
    next_second = dors_pkg::R1_MUTE;
    next_div = first_route_reg[dors_pkg::DIV_CHOICE_BIT];
    if (route_override_i)
    begin
      // fields drive the muxes directly; pin and shared field are ignored
      next_first = route_field(first_route_reg);
      next_second = route_field(second_route_reg);
      // invalid codes pass through unchanged; their effect is undefined
    end
    else
    begin
      case (ctrl_code)
        dors_pkg::DORS_CTRL_MUTE:
        begin
          next_first = dors_pkg::R0_MUTE;
          next_second = dors_pkg::R1_MUTE;
        end
        dors_pkg::DORS_CTRL_CLOCK:
        begin
          if (locked)
          begin
            next_first = dors_pkg::R0_RETIMED;
            next_second = above_3g ? dors_pkg::R1_DIVIDED : dors_pkg::R1_VCO;
            next_div = 1'b1;
          end
          else
          begin
            next_first = dors_pkg::R0_RAW;
            next_second = dors_pkg::R1_MUTE;
          end
        end
        dors_pkg::DORS_CTRL_RETIME:
        begin
          next_first = locked ? dors_pkg::R0_RETIMED : dors_pkg::R0_RAW;
          next_second = locked ? dors_pkg::R1_RETIMED : dors_pkg::R1_RAW;
        end
        default:
        begin
          next_first = dors_pkg::R0_RAW;
          next_second = dors_pkg::R1_RAW;
        end
      endcase
    end
  end

  // applied selection, registered onto the output mux controls
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      first_output_route_code_o <= dors_pkg::R0_MUTE;
      second_output_route_code_o <= dors_pkg::R1_MUTE;
      divided_clock_choice_o <= 1'b0;
    end
    else
    begin
      first_output_route_code_o <= next_first;
      second_output_route_code_o <= next_second;
      divided_clock_choice_o <= next_div;
    end
  end

  // only the second driver has a polarity control
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      second_output_invert_o <= 1'b0;
    else
      second_output_invert_o <= second_pol_reg[dors_pkg::INVERT_BIT];
  end

  // reads: route fields report the applied codes, not the stored ones
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        dors_pkg::ADDR_FIRST_ROUTE:
          reg_rdata_o <= readback(first_output_route_code_o, first_route_reg);
        dors_pkg::ADDR_SECOND_ROUTE:
          reg_rdata_o <= readback(second_output_route_code_o, second_route_reg);
        dors_pkg::ADDR_SECOND_POL: reg_rdata_o <= second_pol_reg;
        // reserved bytes hold nothing and read as zero
        dors_pkg::ADDR_RSVD_1D, dors_pkg::ADDR_RSVD_20, dors_pkg::ADDR_RSVD_21, dors_pkg::ADDR_RSVD_22:
          reg_rdata_o <= 8'h00;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// File: verif/dors_host.sv
// host model: single-byte register cycles on the route select port
// assumes the register port runs on clk_i with one-cycle strobes
`timescale 1ns/1ps
module dors_host (
  input logic clk_i,
  input logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // callers hand in listed route codes only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    @(posedge clk_i);
    #1 d = reg_rdata_i;
  endtask
endmodule

// File: verif/dors_checker.sv
// port checker for the route select block
// assumes pin, lock and rate settle within three edges
`timescale 1ns/1ps
module dors_checker (
  input logic clk_i,
  input logic rst_b_i,
  input logic [7:0] reg_addr_i,
  input logic reg_rd_i,
  input logic [7:0] reg_rdata_o,
  input logic route_override_i,
  input logic ctrl_pin_override_i,
  input logic [1:0] out_ctrl_pin_i,
  input logic cdr_locked_i,
  input logic rate_above_3g_i,
  input logic [2:0] first_output_route_code_o,
  input logic [2:0] second_output_route_code_o,
  input logic divided_clock_choice_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire [5:0] m = {route_override_i, ctrl_pin_override_i, out_ctrl_pin_i, cdr_locked_i, rate_above_3g_i};
  wire [2:0] f = first_output_route_code_o;
  wire [2:0] s = second_output_route_code_o;
  // five samples: two sync flops, the route register, one spare for the edge that releases reset
  a_pin_mute: assert property ((m[5:2] == 4'h0) [*5] |-> f == 3'h0 && s == 3'h7)
    else $error("mute route wrong");
  a_clk_unlock: assert property ((m[5:1] == 5'h02) [*5] |-> f == 3'h2 && s == 3'h7)
    else $error("clock mode unlocked wrong");
  a_clk_slow: assert property ((m == 6'h06) [*5] |-> f == 3'h4 && s == 3'h2)
    else $error("clock mode slow rate wrong");
  a_clk_fast: assert property ((m == 6'h07) [*5] |-> s == 3'h5 && divided_clock_choice_o)
    else $error("clock mode fast rate wrong");
  a_retime_lock: assert property ((m[5:1] == 5'h05) [*5] |-> f == 3'h4 && s == 3'h1)
    else $error("retime locked wrong");
  a_retime_unlock: assert property ((m[5:1] == 5'h04) [*5] |-> f == 3'h2 && s == 3'h0)
    else $error("retime unlocked wrong");
  a_raw_both: assert property ((m[5:2] == 4'h3) [*5] |-> f == 3'h2 && s == 3'h0)
    else $error("raw route wrong");
  a_read_first: assert property (reg_rd_i && reg_addr_i == 8'h1c |=> reg_rdata_o[7:5] == $past(f))
    else $error("first route readback wrong");
  a_read_second: assert property (reg_rd_i && reg_addr_i == 8'h1e |=> reg_rdata_o[7:5] == $past(s))
    else $error("second route readback wrong");
endmodule
bind dors_route_select dors_checker chk (.clk_i, .rst_b_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
  .route_override_i, .ctrl_pin_override_i, .out_ctrl_pin_i, .cdr_locked_i, .rate_above_3g_i,
  .first_output_route_code_o, .second_output_route_code_o, .divided_clock_choice_o);

// File: verif/testbench.sv
// bench: shared control table through pin and field, then override cases
// assumes host model and checker are compiled first
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ro = 1'b0;
  logic co = 1'b0;
  logic [1:0] pin = 2'h2;
  logic lk = 1'b0;
  logic rt = 1'b0;
  logic [7:0] a, wd, rdat, d;
  logic wr, rd, dv, inv;
  logic [2:0] f, s;
  int n_fail = 0;
  int comparisons = 0;
  // ctrl, lock, rate, first code, second code
  logic [9:0] rows [7] = '{10'h087, 10'h117, 10'h1a2, 10'h1e5, 10'h2a1, 10'h210, 10'h390};
  logic [2:0] c0 [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h4};
  logic [2:0] c1 [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h5};
  always #2.5 clk_i = ~clk_i;
  dors_host host (.clk_i, .reg_rdata_i(rdat), .reg_addr_o(a), .reg_wr_o(wr), .reg_wdata_o(wd), .reg_rd_o(rd));
  dors_route_select dut (.clk_i, .rst_b_i, .reg_addr_i(a), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .route_override_i(ro), .ctrl_pin_override_i(co), .out_ctrl_pin_i(pin),
    .cdr_locked_i(lk), .rate_above_3g_i(rt), .first_output_route_code_o(f),
    .second_output_route_code_o(s), .divided_clock_choice_o(dv), .second_output_invert_o(inv));
  task automatic cmp(input string n, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // pin and lock pass two sync flops before the route register
  task automatic settle;
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  initial
  begin
    #20000;
    n_fail++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    settle();
    host.rd(8'h1c, d);
    cmp("reg 1c", d, 8'h58);
    host.rd(8'h1f, d);
    cmp("reg 1f", d, 8'h10);
    host.wr(8'h1d, 8'hff);
    host.rd(8'h1d, d);
    cmp("reg 1d", d, 8'h00);
    // second pass drives the field with the pin set to the opposite code
    for (int p = 0; p < 2; p++)
      foreach (rows[i])
      begin
        @(posedge clk_i);
        {pin, lk, rt} <= rows[i][9:6] ^ {p[0], p[0], 2'h0};
        co <= p[0];
        // choice bit written 0 on the second pass only, so there only the forced vco/40 can raise div; the first pass keeps reset 1
        if (p[0])
          host.wr(8'h1c, {3'h2, 1'b0, rows[i][9:8], 2'h0});
        settle();
        cmp("first", 8'(f), 8'(rows[i][5:3]));
        cmp("second", 8'(s), 8'(rows[i][2:0]));
        if (rows[i][2:0] == 3'h5)
          cmp("div", 8'(dv), 8'h01);
        host.rd(8'h1e, d);
        cmp("reg 1e", d, {rows[i][2:0], 5'h09});
        if (p[0])
          host.rd(8'h1c, d);
        if (p[0])
          cmp("reg 1c", d, {rows[i][5:3], 1'b0, rows[i][9:8], 2'h0});
      end
    @(posedge clk_i);
    ro <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      host.wr(8'h1c, {c0[i], 5'h08});
      host.wr(8'h1e, {c1[i], 5'h09});
      settle();
      cmp("first", 8'(f), 8'(c0[i]));
      cmp("second", 8'(s), 8'(c1[i]));
      cmp("div", 8'(dv), 8'h00);
    end
    host.wr(8'h1c, 8'h98);
    host.wr(8'h1f, 8'h80);
    settle();
    cmp("div", 8'(dv), 8'h01);
    cmp("invert", 8'(inv), 8'h01);
    cmp("first", 8'(f), 8'h04);
    host.wr(8'h1f, 8'h00);
    settle();
    cmp("invert", 8'(inv), 8'h00);
    // reset in mid-run with override on: muxes mute, stored bytes back to defaults
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    @(posedge clk_i);
    #1;
    cmp("reset first", 8'(f), 8'h00);
    cmp("reset second", 8'(s), 8'h07);
    cmp("reset invert", 8'(inv), 8'h00);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    settle();
    cmp("first", 8'(f), 8'h02);
    cmp("second", 8'(s), 8'h00);
    cmp("div", 8'(dv), 8'h01);
    host.rd(8'h1e, d);
    cmp("reg 1e", d, 8'h09);
    host.rd(8'h1c, d);
    cmp("reg 1c", d, 8'h58);
    close_out();
  end
endmodule
